// [hdl/cbg_display.sv]
// cbg_display: LED bar-graph controller of the fuel gauge
// assumes the request pin has an external pull-up and is synchronous to clk;
// relSoc and absSoc arrive from the gauge core, already in percent
//
// What this block does
// [RULE1] drives three, four or five segments, count chosen by configuration bits
// [RULE2] relative mode references full charge capacity, absolute mode design capacity
// [RULE3] reference-select bit in pack configuration byte picks absolute or relative
// [RULE4] falling request edge lights display and starts a four second timer
// [RULE5] request must go high then fall again; edges before timer expiry ignored
// [RULE6] end-of-discharge flag blanks all segments and blocks activation
// [RULE7] programmable delay between lighting successive segments; zero disables it
// [RULE8] blink active segments when remaining capacity is below alarm value
// [RULE9] each segment an equal share of relative or absolute state of charge
// [RULE10] five segments: thresholds at 20, 40, 60 and 80 percent
// [RULE11] four segments: thresholds at 25, 50 and 75 percent
// [RULE12] three segments: thresholds at 34 and 67 percent
// [RULE13] timer expiry blanks segments; blink rate is a fixed fraction of second
// [RULE14] sequencing lights from segment 1 up to the called-for count only
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cbg_display
    import cbg_pkg::*;
#(
    parameter int DISPLAY_REQUEST_INPUT_CYCLES = DISPLAY_REQUEST_INPUT_CYCLES_DEF,
    parameter int BLINK_CYCLES = BLINK_CYCLES_DEF,
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic displayRequestIn,
    input wire cbg_gauge_t gauge,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic [SEG_N-1:0] ledOn
);
    // ==========================================================
    // state
    typedef struct packed {
        cbg_state_t fsm;
        logic [7:0] packCfg;
        logic [7:0] ledDelay;
        logic [CNT_W-1:0] dispCnt;
        logic [CNT_W-1:0] blinkCnt;
        logic blinkPhase;
        logic [CNT_W-1:0] stepCnt;
        logic [7:0] stepUnits;
        logic [2:0] litCnt;
        logic [SEG_N-1:0] led;
        logic [7:0] rdata;
    } cbg_st_t;
    cbg_st_t st_reg;
    cbg_st_t st_next;

    logic reqFall;
    logic reqLevel;
    logic [6:0] socSel;
    logic [2:0] target;
    logic refAbs;
    logic [1:0] ledSel;
    logic lowCap;
    logic [SEG_N-1:0] barMask;

    cbg_edge_det u_edge (
        .clk(clk),
        .rst(rst),
        .pin(displayRequestIn),
        .fall(reqFall),
        .level(reqLevel)
    );

    // ==========================================================
    // level selection
    assign refAbs = st_reg.packCfg[CFG_REFSEL_BIT]; // RULE3
    assign ledSel = st_reg.packCfg[CFG_LEDSEL_LO+1:CFG_LEDSEL_LO]; // RULE1
    // absolute soc is already scaled to design capacity by the gauge core
    assign socSel = refAbs ? gauge.absSoc : gauge.relSoc; // RULE2 RULE9
    assign lowCap = gauge.remCap < gauge.remCapAlarm; // RULE8

    cbg_level_map u_map (
        .soc(socSel),
        .ledSel(ledSel),
        .count(target)
    );

    genvar gi;
    generate
        for (gi = 0; gi < SEG_N; gi++) begin : g_mask
            assign barMask[gi] = (3'(gi) < st_reg.litCnt); // RULE14
        end
    endgenerate

    // ==========================================================
    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        if (regWr) begin
            unique case (regAddr)
                ADDR_PACK_CFG: st_next.packCfg = regWdata;
                ADDR_LED_DELAY: st_next.ledDelay = regWdata;
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                ADDR_PACK_CFG: st_next.rdata = st_reg.packCfg;
                ADDR_LED_DELAY: st_next.rdata = st_reg.ledDelay;
                ADDR_SOC: st_next.rdata = {1'b0, socSel};
                ADDR_STATUS: st_next.rdata = {4'h0, lowCap, gauge.endOfDischarge,
                                              st_reg.fsm};
                ADDR_LED_CNT: st_next.rdata = {5'h00, st_reg.litCnt};
                default: st_next.rdata = 8'h00;
            endcase
        end

        // free-running blink timebase
        if (st_reg.blinkCnt >= CNT_W'(BLINK_CYCLES - 1)) begin // RULE13
            st_next.blinkCnt = '0;
            st_next.blinkPhase = ~st_reg.blinkPhase;
        end else begin
            st_next.blinkCnt = st_reg.blinkCnt + 1'b1;
        end

        unique case (st_reg.fsm)
            CBG_IDLE: begin
                st_next.litCnt = 3'h0;
                if (reqFall && !gauge.endOfDischarge) begin // RULE4 RULE6
                    st_next.fsm = CBG_SHOW;
                    st_next.dispCnt = '0;
                    st_next.stepCnt = '0;
                    st_next.stepUnits = 8'h00;
                    // sequencing starts at segment 1; zero delay lights all at once
                    st_next.litCnt = (st_reg.ledDelay == 8'h00) ? target : 3'h1; // RULE7
                end
            end
            CBG_SHOW: begin
                st_next.dispCnt = st_reg.dispCnt + 1'b1;
                if (st_reg.ledDelay == 8'h00) begin
                    st_next.litCnt = target; // RULE7
                end else if (st_reg.litCnt < target) begin
                    if (st_reg.stepCnt >= CNT_W'(STEP_CYCLES - 1)) begin
                        st_next.stepCnt = '0;
                        if (st_reg.stepUnits >= st_reg.ledDelay - 8'h01) begin
                            st_next.stepUnits = 8'h00;
                            st_next.litCnt = st_reg.litCnt + 3'h1; // RULE14
                        end else begin
                            st_next.stepUnits = st_reg.stepUnits + 8'h01;
                        end
                    end else begin
                        st_next.stepCnt = st_reg.stepCnt + 1'b1;
                    end
                end else begin
                    // soc dropped while shown: never exceed the called-for count
                    st_next.litCnt = target; // RULE14
                end
                if (st_reg.dispCnt >= CNT_W'(DISPLAY_REQUEST_INPUT_CYCLES - 1)) begin // RULE4
                    st_next.litCnt = 3'h0; // RULE13
                    st_next.fsm = reqLevel ? CBG_IDLE : CBG_WAIT_HIGH; // RULE5
                end
            end
            CBG_WAIT_HIGH: begin
                st_next.litCnt = 3'h0;
                if (reqLevel) st_next.fsm = CBG_IDLE; // RULE5
            end
            default: st_next.fsm = CBG_IDLE;
        endcase

        if (gauge.endOfDischarge) begin
            st_next.led = '0; // RULE6
        end else if (lowCap && st_next.blinkPhase) begin
            st_next.led = '0; // RULE8
        end else begin
            st_next.led = '0;
            for (int i = 0; i < SEG_N; i++) begin
                st_next.led[i] = (3'(i) < st_next.litCnt);
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg.fsm <= CBG_IDLE;
            st_reg.packCfg <= PACK_CFG_RST;
            st_reg.ledDelay <= LED_DELAY_RST;
            st_reg.dispCnt <= '0;
            st_reg.blinkCnt <= '0;
            st_reg.blinkPhase <= 1'b0;
            st_reg.stepCnt <= '0;
            st_reg.stepUnits <= 8'h00;
            st_reg.litCnt <= 3'h0;
            st_reg.led <= '0;
            st_reg.rdata <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ledOn = st_reg.led;
    assign regRdata = st_reg.rdata;

    // ==========================================================
    // checks
    sequence s_fall_ok;
        reqFall && !gauge.endOfDischarge && st_reg.fsm == CBG_IDLE;
    endsequence

    sequence s_shown;
        st_reg.fsm == CBG_SHOW;
    endsequence

    a_start_show: assert property (@(posedge clk) disable iff (rst) // RULE4
        s_fall_ok |=> s_shown)
        else $error("display did not start on request edge");

    a_eod_blank: assert property (@(posedge clk) disable iff (rst) // RULE6
        $past(gauge.endOfDischarge) |-> ledOn == '0)
        else $error("segments lit during end of discharge");

    a_eod_noact: assert property (@(posedge clk) disable iff (rst) // RULE6
        (st_reg.fsm == CBG_IDLE && gauge.endOfDischarge) |=> st_reg.fsm == CBG_IDLE)
        else $error("activated during end of discharge");

    a_ignore_show: assert property (@(posedge clk) disable iff (rst) // RULE5
        (st_reg.fsm == CBG_SHOW && st_reg.dispCnt < CNT_W'(DISPLAY_REQUEST_INPUT_CYCLES - 1))
        |=> st_reg.fsm == CBG_SHOW && st_reg.dispCnt == $past(st_reg.dispCnt) + 1'b1)
        else $error("display timer disturbed before expiry");

    a_wait_high: assert property (@(posedge clk) disable iff (rst) // RULE5
        (st_reg.fsm == CBG_WAIT_HIGH && !reqLevel) |=> st_reg.fsm == CBG_WAIT_HIGH)
        else $error("left wait state while request still low");

    a_expire_off: assert property (@(posedge clk) disable iff (rst) // RULE13
        (st_reg.fsm == CBG_SHOW && st_reg.dispCnt == CNT_W'(DISPLAY_REQUEST_INPUT_CYCLES - 1))
        |=> st_reg.fsm != CBG_SHOW && ledOn == '0)
        else $error("segments not cleared at timer expiry");

    // the delay in force at the request edge is the old one, hence the past value
    a_no_excess: assert property (@(posedge clk) disable iff (rst) // RULE14
        ($past(st_reg.ledDelay) != 8'h00 && $rose(st_reg.fsm == CBG_SHOW))
        |-> st_reg.litCnt == 3'h1)
        else $error("sequencing did not start at segment one");

    a_lit_bound: assert property (@(posedge clk) disable iff (rst) // RULE1
        st_reg.litCnt <= SEG_MAX)
        else $error("lit count above segment count");

    a_show_lit: assert property (@(posedge clk) disable iff (rst) // RULE10
        s_shown |-> st_reg.litCnt >= 3'h1)
        else $error("display shown with no segment lit");

    a_four_cap: assert property (@(posedge clk) disable iff (rst) // RULE11
        ledSel == LEDSEL_FOUR |-> target <= 3'h4)
        else $error("four-segment mode asked for a fifth segment");

    a_three_cap: assert property (@(posedge clk) disable iff (rst) // RULE12
        ledSel == LEDSEL_THREE |-> target <= 3'h3)
        else $error("three-segment mode asked for a fourth segment");

    // outside the show state nothing may stay lit, whatever the last request did
    a_idle_dark: assert property (@(posedge clk) disable iff (rst) // RULE13
        !(st_reg.fsm == CBG_SHOW) |-> st_reg.litCnt == 3'h0)
        else $error("segments counted outside the show state");

    a_wait_leave: assert property (@(posedge clk) disable iff (rst) // RULE5
        (st_reg.fsm == CBG_WAIT_HIGH && reqLevel) |=> st_reg.fsm == CBG_IDLE)
        else $error("wait state not left with request high");

    sequence s_seq_wait;
        st_reg.ledDelay != 8'h00 && st_reg.litCnt < target
        && st_reg.stepCnt < CNT_W'(STEP_CYCLES - 1)
        && st_reg.dispCnt < CNT_W'(DISPLAY_REQUEST_INPUT_CYCLES - 1);
    endsequence

    a_seq_hold: assert property (@(posedge clk) disable iff (rst) // RULE7
        (s_shown and s_seq_wait) |=> st_reg.litCnt == $past(st_reg.litCnt))
        else $error("segment lit before its delay ran out");

    a_cfg_write: assert property (@(posedge clk) disable iff (rst) // RULE3
        (regWr && regAddr == ADDR_PACK_CFG) |=> st_reg.packCfg == $past(regWdata))
        else $error("pack configuration write lost");

    a_delay_write: assert property (@(posedge clk) disable iff (rst) // RULE7
        (regWr && regAddr == ADDR_LED_DELAY) |=> st_reg.ledDelay == $past(regWdata))
        else $error("delay write lost");

    // read data stands one cycle only, so a stale value never looks like an answer
    a_rdata_quiet: assert property (@(posedge clk) disable iff (rst) // RULE3
        !regRd |=> regRdata == 8'h00)
        else $error("read data shown without a read");

    a_cfg_read: assert property (@(posedge clk) disable iff (rst) // RULE3
        (regRd && regAddr == ADDR_PACK_CFG) |=> regRdata == $past(st_reg.packCfg))
        else $error("pack configuration read wrong");

    a_cnt_read: assert property (@(posedge clk) disable iff (rst) // RULE14
        (regRd && regAddr == ADDR_LED_CNT) |=> regRdata == {5'h00, $past(st_reg.litCnt)})
        else $error("lit count read wrong");

    a_zero_delay: assert property (@(posedge clk) disable iff (rst) // RULE7
        (s_shown and (st_reg.ledDelay == 8'h00 && $stable(target)))
        |=> st_reg.fsm != CBG_SHOW || st_reg.litCnt == $past(target))
        else $error("zero delay did not light all segments at once");

    a_blink_dark: assert property (@(posedge clk) disable iff (rst) // RULE8
        ($past(lowCap) && $past(st_next.blinkPhase)) |-> ledOn == '0)
        else $error("segments lit in dark blink phase");

    a_bar_mask: assert property (@(posedge clk) disable iff (rst) // RULE1
        ($past(gauge.endOfDischarge) == 1'b0 && $past(lowCap) == 1'b0)
        |-> ledOn == barMask)
        else $error("segment pattern not a contiguous bar");
endmodule : cbg_display
`default_nettype wire

// [hdl/cbg_edge_det.sv]
// cbg_edge_det: falling-edge detector for the request pin
// assumes the pin is already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module cbg_edge_det
    import cbg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic fall,
    output logic level
);
    typedef struct packed {
        logic prev;
    } cbg_edge_st_t;
    cbg_edge_st_t st_reg;
    cbg_edge_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.prev = pin;
    end

    // idle-high reset, so a button held low through reset is seen as an edge once reset ends
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg.prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fall = st_reg.prev & ~pin;
    assign level = pin;
endmodule : cbg_edge_det
`default_nettype wire

// [hdl/cbg_level_map.sv]
// cbg_level_map: state of charge to lit-segment count
// pure combinational; soc is a percentage 0..100
`timescale 1ns/100ps
`default_nettype none
module cbg_level_map
    import cbg_pkg::*;
(
    input wire logic [6:0] soc,
    input wire logic [1:0] ledSel,
    output logic [2:0] count
);
    always_comb begin
        count = 3'h1;
        unique case (ledSel)
            LEDSEL_FOUR: begin
                if (soc >= P75) count = 3'h4; // RULE11
                else if (soc >= P50) count = 3'h3;
                else if (soc >= P25) count = 3'h2;
            end
            LEDSEL_THREE: begin
                if (soc >= P67) count = 3'h3; // RULE12
                else if (soc >= P34) count = 3'h2;
            end
            default: begin
                if (soc >= P80) count = 3'h5; // RULE10
                else if (soc >= P60) count = 3'h4;
                else if (soc >= P40) count = 3'h3;
                else if (soc >= P20) count = 3'h2;
            end
        endcase
    end
endmodule : cbg_level_map
`default_nettype wire

// [hdl/cbg_pkg.sv]
// cbg_pkg: constants and types shared by the charge bar-graph display block
// assumes a 250 MHz clock; all times are converted to cycles here
package cbg_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 250;
    localparam int DISPLAY_REQUEST_INPUT_TIME_MS = 4000;
    localparam int DISPLAY_REQUEST_INPUT_CYCLES_DEF = DISPLAY_REQUEST_INPUT_TIME_MS * 1000 * CLK_MHZ;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_CYCLES_DEF = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam int STEP_MS = 100;
    localparam int STEP_CYCLES_DEF = STEP_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;

    // ==========================================================
    // register map, index addresses on the plain register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_PACK_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_LED_DELAY = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SOC = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_LED_CNT = 4'h4;
    localparam logic [7:0] PACK_CFG_ADDR = 8'h28;

    // pack configuration fields
    localparam int CFG_REFSEL_BIT = 0;
    localparam int CFG_LEDSEL_LO = 1;
    localparam logic [7:0] PACK_CFG_RST = 8'h00;
    localparam logic [7:0] LED_DELAY_RST = 8'h00;

    // segment count select
    localparam logic [1:0] LEDSEL_FIVE = 2'h0;
    localparam logic [1:0] LEDSEL_FOUR = 2'h1;
    localparam logic [1:0] LEDSEL_THREE = 2'h2;

    localparam int SEG_N = 5;
    localparam logic [2:0] SEG_MAX = 3'h5;

    // thresholds in percent
    localparam logic [6:0] P20 = 7'h14;
    localparam logic [6:0] P40 = 7'h28;
    localparam logic [6:0] P60 = 7'h3c;
    localparam logic [6:0] P80 = 7'h50;
    localparam logic [6:0] P25 = 7'h19;
    localparam logic [6:0] P50 = 7'h32;
    localparam logic [6:0] P75 = 7'h4b;
    localparam logic [6:0] P34 = 7'h22;
    localparam logic [6:0] P67 = 7'h43;

    typedef enum logic [1:0] {
        CBG_IDLE = 2'b00,
        CBG_SHOW = 2'b01,
        CBG_WAIT_HIGH = 2'b10
    } cbg_state_t;

    typedef struct packed {
        logic [15:0] remCap;
        logic [15:0] remCapAlarm;
        logic [6:0] relSoc;
        logic [6:0] absSoc;
        logic endOfDischarge;
    } cbg_gauge_t;
endpackage : cbg_pkg

// [testbench/cbg_button_model.sv]
// cbg_button_model: pushbutton with pull-up and the LED bar on the far side
// assumes the bench changes pressed just after a rising clk edge
`timescale 1ns/100ps
`default_nettype none
module cbg_button_model
    import cbg_pkg::*;
(
    input wire logic pressed,
    input wire logic [SEG_N-1:0] ledOn,
    output logic pin,
    output logic [2:0] litCount
);
    // ============================================================
    // pin and segments
    // the pull-up holds the line high whenever the switch is open
    assign pin = pressed ? 1'b0 : 1'b1;
    always_comb begin
        litCount = 3'h0;
        for (int i = 0; i < SEG_N; i++) begin
            litCount = litCount + {2'h0, ledOn[i]};
        end
    end
endmodule : cbg_button_model
`default_nettype wire

// [testbench/charge_bar_graph_display_tb_top.sv]
// charge_bar_graph_display_tb_top: self-checking bench of the bar-graph display
// assumes shortened timer parameters; all counts derive from the locals below
`timescale 1ns/100ps
`default_nettype none
module charge_bar_graph_display_tb_top;
    import cbg_pkg::*;
    localparam int DISPLAY_REQUEST_INPUT_N = 200;
    localparam int BLINK_N = 8;
    localparam int STEP_N = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pressed = 1'b0;
    logic pin;
    logic [2:0] litCount;
    cbg_gauge_t gauge = '0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [SEG_N-1:0] ledOn;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 1;
    logic [6:0] corner [20] = '{7'h00, 7'h13, 7'h14, 7'h18, 7'h19, 7'h21, 7'h22, 7'h27, 7'h28,
        7'h31, 7'h32, 7'h3b, 7'h3c, 7'h42, 7'h43, 7'h4a, 7'h4b, 7'h4f, 7'h50, 7'h64};

    cbg_display #(.DISPLAY_REQUEST_INPUT_CYCLES(DISPLAY_REQUEST_INPUT_N), .BLINK_CYCLES(BLINK_N), .STEP_CYCLES(STEP_N))
    cbg_display_inst (.clk(clk), .rst(rst), .displayRequestIn(pin), .gauge(gauge),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .ledOn(ledOn));
    cbg_button_model cbg_button_model_inst (.pressed(pressed), .ledOn(ledOn), .pin(pin),
        .litCount(litCount));

    initial begin
        forever #2 clk = ~clk;
    end

    // ============================================================
    // expectations
    function automatic logic [2:0] expCount(input logic [6:0] soc, input logic [1:0] sel);
        if (sel == LEDSEL_FOUR) return (soc >= P75) ? 3'h4 : (soc >= P50) ? 3'h3 :
            (soc >= P25) ? 3'h2 : 3'h1;
        if (sel == LEDSEL_THREE) return (soc >= P67) ? 3'h3 : (soc >= P34) ? 3'h2 : 3'h1;
        return (soc >= P80) ? 3'h5 : (soc >= P60) ? 3'h4 : (soc >= P40) ? 3'h3 :
            (soc >= P20) ? 3'h2 : 3'h1;
    endfunction : expCount

    function automatic logic [SEG_N-1:0] bar(input logic [2:0] n);
        logic [5:0] t;
        t = (6'h01 << n) - 6'h01;
        return t[SEG_N-1:0];
    endfunction : bar

    // ============================================================
    // bus and pin tasks
    task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
        samples_checked++;
        if (got !== expv) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, expv, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [7:0] w);
        @(posedge clk);
        regAddr <= a;
        regWdata <= w;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [ADDR_W-1:0] a, output logic [7:0] q);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 q = regRdata;
    endtask : regRead

    task automatic setGauge(input logic [6:0] rel, input logic [6:0] abs,
        input logic [15:0] rc, input logic [15:0] al, input logic eod);
        @(posedge clk);
        gauge <= '{remCap: rc, remCapAlarm: al, relSoc: rel, absSoc: abs, endOfDischarge: eod};
    endtask : setGauge

    task automatic pushOnce();
        @(posedge clk);
        pressed <= 1'b1;
        tick(3);
        pressed <= 1'b0;
    endtask : pushOnce

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // a hang counts as a mismatch and still reaches the verdict
    initial begin
        tick(100000);
        err_total++;
        test_done();
    end

    // ============================================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic [6:0] a;
        logic [6:0] v;
        int hi;
        int lo;
        int t1;
        int t3;
        tick(4);
        rst <= 1'b0;
        regRead(ADDR_PACK_CFG, d);
        check("packCfg", PACK_CFG_RST, d);
        regRead(ADDR_LED_DELAY, d);
        check("ledDelay", LED_DELAY_RST, d);
        regWrite(4'hf, 8'h5a);
        regRead(4'hf, d);
        check("unmapped", 8'h00, d);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                regWrite(ADDR_PACK_CFG, {5'h00, s[1:0], m[0]});
                pushOnce();
                for (int k = 0; k < 20; k++) begin
                    a = 7'($unsigned($random(seed)) % 101);
                    setGauge(corner[k], a, 16'h0100, 16'h0010, 1'b0);
                    tick(3);
                    v = m[0] ? a : corner[k];
                    check("ledOn", {3'h0, bar(expCount(v, s[1:0]))}, {3'h0, ledOn});
                    regRead(ADDR_SOC, d);
                    check("soc", {1'b0, v}, d);
                end
                tick(DISPLAY_REQUEST_INPUT_N);
                check("expired", 8'h00, {3'h0, ledOn});
            end
        end
        $display("test level map done");
        regWrite(ADDR_PACK_CFG, 8'h00);
        setGauge(7'h64, 7'h64, 16'h0100, 16'h0010, 1'b0);
        pushOnce();
        tick(DISPLAY_REQUEST_INPUT_N / 2);
        pushOnce();
        tick(DISPLAY_REQUEST_INPUT_N / 2 - 16);
        check("early", 8'h1f, {3'h0, ledOn});
        tick(16);
        check("noRetrigger", 8'h00, {3'h0, ledOn});
        @(posedge clk);
        pressed <= 1'b1;
        tick(DISPLAY_REQUEST_INPUT_N + 8);
        check("heldLow", 8'h00, {3'h0, ledOn});
        regRead(ADDR_STATUS, d);
        check("waitHigh", 8'h02, d);
        pressed <= 1'b0;
        tick(3);
        regRead(ADDR_STATUS, d);
        check("idle", 8'h00, d);
        pushOnce();
        check("again", 8'h1f, {3'h0, ledOn});
        tick(DISPLAY_REQUEST_INPUT_N);
        $display("test timer done");
        setGauge(7'h64, 7'h64, 16'h0100, 16'h0010, 1'b1);
        pushOnce();
        tick(2);
        check("eodBlank", 8'h00, {3'h0, ledOn});
        regRead(ADDR_STATUS, d);
        check("eodIdle", 8'h04, d);
        setGauge(7'h64, 7'h64, 16'h0100, 16'h0010, 1'b0);
        pushOnce();
        tick(2);
        check("eodClear", 8'h1f, {3'h0, ledOn});
        setGauge(7'h64, 7'h64, 16'h0100, 16'h0010, 1'b1);
        tick(3);
        check("eodShow", 8'h00, {3'h0, ledOn});
        setGauge(7'h64, 7'h64, 16'h0100, 16'h0010, 1'b0);
        tick(DISPLAY_REQUEST_INPUT_N);
        $display("test discharge done");
        setGauge(7'h64, 7'h64, 16'h0005, 16'h0010, 1'b0);
        pushOnce();
        tick(2);
        regRead(ADDR_STATUS, d);
        check("lowCap", 8'h09, d);
        hi = 0;
        lo = 0;
        repeat (4 * BLINK_N) begin
            @(posedge clk);
            #1;
            if (ledOn === 5'h1f) hi++;
            else if (ledOn === 5'h00) lo++;
        end
        check("blinkLo", 8'(2 * BLINK_N), 8'(lo));
        check("blinkHi", 8'(2 * BLINK_N), 8'(hi));
        tick(DISPLAY_REQUEST_INPUT_N);
        $display("test blink done");
        regWrite(ADDR_LED_DELAY, 8'h02);
        setGauge(7'h32, 7'h00, 16'h0100, 16'h0010, 1'b0);
        t1 = -1;
        t3 = -1;
        @(posedge clk);
        pressed <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            #1;
            if (litCount === 3'h1 && t1 < 0) t1 = i;
            if (litCount === 3'h3 && t3 < 0) t3 = i;
            check("seqBar", 8'h00, {7'h00, (ledOn !== bar(litCount)) || litCount > 3'h3});
        end
        pressed <= 1'b0;
        check("seqStep", 8'(4 * STEP_N), 8'(t3 - t1));
        regRead(ADDR_LED_CNT, d);
        check("litCnt", 8'h03, d);
        regWrite(ADDR_LED_DELAY, 8'h00);
        tick(DISPLAY_REQUEST_INPUT_N);
        $display("test sequencing done");
        test_done();
    end
endmodule : charge_bar_graph_display_tb_top
`default_nettype wire
